// >>> design/serial_rx_defines.svh
// register map, field positions and reset values of the receive status block
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_DATA 8'h08
`define OFS_BAUD 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14

// control register fields
`define CTRL_PORT_ON 0
`define CTRL_RX_ON 1
`define CTRL_WIDE 2
`define CTRL_ADDR_DET 3
`define CTRL_W 4
`define CTRL_RESET 4'h0

// status register fields
`define STAT_FRAME 0
`define STAT_OVERRUN 1
`define STAT_NINTH 2
`define STAT_AVAIL 3

// interrupt status and mask fields
`define IRQ_RXCHAR 0
`define IRQ_OVERRUN 1
`define IRQ_W 2
`define IRQ_MASK_RESET 2'h0

// bit period in pclk cycles after reset
`define BAUD_W 16
`define BAUD_RESET 16'h0010

// character widths in data bits
`define BITS_NARROW 4'h8
`define BITS_WIDE 4'h9

`endif

// >>> design/serial_rx_pkg.sv
// types shared by the receive status block
package serial_rx_pkg;

  // receiver sequencing states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_t;

endpackage

// >>> design/async_serial_receive_status.sv
// apb receive side of an asynchronous serial port with status and filters
//
// Behaviour
// - each queued character keeps its own framing error; flag shows oldest
// - stop bit sampled low at its bit time marks a framing error
// - framing flag is read-only; a data read advances to next entry
// - a framing error never stops later characters being queued
// - clearing serial_port_enable resets the unit and clears the flag
// - clearing continuous_receive_enable leaves the framing flag alone
// - framing error alone raises no interrupt
// - queue holds two; a third complete character sets overrun
// - during overrun queued data stays readable, nothing new accepted
// - overrun cleared by dropping receive enable or serial port enable
// - nine-bit mode shifts nine data bits per character
// - ninth bit shows msb of oldest entry; read it before data
// - address detect queues only characters whose ninth bit is set
`timescale 1ns/1ps
`include "serial_rx_defines.svh"

module async_serial_receive_status #(
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx,
  output logic irq
);
  import serial_rx_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

  // address compare shared by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [`CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [`BAUD_W-1:0] baud_ff, nxt_baud;
  logic [`IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [`IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [`IRQ_W-1:0] irq_clr_ff, nxt_irq_clr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic pop_ok_ff, nxt_pop_ok;
  logic irq_ff, nxt_irq;
  rx_state_t state_ff, nxt_state;
  logic [`BAUD_W-1:0] tmr_ff, nxt_tmr;
  logic [3:0] bitn_ff, nxt_bitn;
  logic [8:0] shreg_ff, nxt_shreg;
  logic ovr_ff, nxt_ovr;
  logic [9:0] mem_ff [DEPTH];
  logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [PW:0] count_ff, nxt_count;
  logic port_on, rx_on, wide, addr_det;
  logic active, done, accept, push, pop, wr_en;
  logic [3:0] nbits;
  logic [8:0] rx_char;
  logic [PW-1:0] wr_ptr;
  logic [9:0] top;
  logic [31:0] status_word;
  logic setup, complete, mapped;

  assign port_on = ctrl_ff[`CTRL_PORT_ON];
  assign rx_on = ctrl_ff[`CTRL_RX_ON];
  assign wide = ctrl_ff[`CTRL_WIDE];
  assign addr_det = ctrl_ff[`CTRL_ADDR_DET];
  assign nbits = wide ? `BITS_WIDE : `BITS_NARROW;
  assign active = port_on && rx_on && !ovr_ff;
  assign top = mem_ff[rd_ptr_ff];
  assign wr_ptr = rd_ptr_ff + count_ff[PW-1:0];

  // apb phases: answer one cycle into the access phase
  assign setup = psel && penable && !pready_ff;
  assign complete = psel && penable && pready_ff;
  assign mapped = hit(paddr, `OFS_CTRL) || hit(paddr, `OFS_STATUS) ||
                  hit(paddr, `OFS_DATA) || hit(paddr, `OFS_BAUD) ||
                  hit(paddr, `OFS_IRQ_STAT) || hit(paddr, `OFS_IRQ_MASK);

  // status word: oldest entry flags plus overrun and data available
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_FRAME] = (count_ff != '0) && top[9];
    status_word[`STAT_OVERRUN] = ovr_ff;
    status_word[`STAT_NINTH] = (count_ff != '0) && top[8];
    status_word[`STAT_AVAIL] = (count_ff != '0);
  end

  // register bus next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_baud = baud_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_pready = setup;
    nxt_pslverr = setup && !mapped;
    nxt_prdata = prdata_ff;
    nxt_pop_ok = 1'b0;
    nxt_irq_clr = '0;
    if (setup && !pwrite) begin
      nxt_prdata = 32'h0000_0000;
      if (hit(paddr, `OFS_CTRL)) nxt_prdata[`CTRL_W-1:0] = ctrl_ff;
      if (hit(paddr, `OFS_STATUS)) nxt_prdata = status_word;
      if (hit(paddr, `OFS_DATA)) begin
        nxt_prdata[7:0] = top[7:0];
        nxt_pop_ok = (count_ff != '0);
      end
      if (hit(paddr, `OFS_BAUD)) nxt_prdata[`BAUD_W-1:0] = baud_ff;
      if (hit(paddr, `OFS_IRQ_STAT)) begin
        nxt_prdata[`IRQ_W-1:0] = irq_stat_ff;
        nxt_irq_clr = irq_stat_ff; // only what the read returned
      end
      if (hit(paddr, `OFS_IRQ_MASK)) nxt_prdata[`IRQ_W-1:0] = irq_mask_ff;
    end
    if (complete && pwrite) begin
      if (hit(paddr, `OFS_CTRL)) nxt_ctrl = pwdata[`CTRL_W-1:0];
      if (hit(paddr, `OFS_BAUD)) nxt_baud = pwdata[`BAUD_W-1:0];
      if (hit(paddr, `OFS_IRQ_MASK)) nxt_irq_mask = pwdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
      baud_ff <= `BAUD_RESET;
      irq_mask_ff <= `IRQ_MASK_RESET;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pop_ok_ff <= 1'b0;
      irq_clr_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      baud_ff <= nxt_baud;
      irq_mask_ff <= nxt_irq_mask;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      pop_ok_ff <= nxt_pop_ok;
      irq_clr_ff <= nxt_irq_clr;
    end
  end

  // receiver sequencing: start check at half bit, then one sample per bit
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_bitn = bitn_ff;
    nxt_shreg = shreg_ff;
    done = 1'b0;
    if (tmr_ff != '0) nxt_tmr = tmr_ff - 1'b1;
    unique case (state_ff)
      RX_IDLE: begin
        if (active && !serial_rx) begin
          nxt_state = RX_START;
          nxt_tmr = baud_ff >> 1;
        end
      end
      RX_START: begin
        if (tmr_ff == '0) begin
          nxt_state = serial_rx ? RX_IDLE : RX_DATA;
          nxt_tmr = baud_ff - 1'b1;
          nxt_bitn = 4'h0;
        end
      end
      RX_DATA: begin
        if (tmr_ff == '0) begin
          nxt_shreg = {serial_rx, shreg_ff[8:1]}; // lsb first
          nxt_bitn = bitn_ff + 4'h1;
          nxt_tmr = baud_ff - 1'b1;
          if (bitn_ff == nbits - 4'h1) nxt_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tmr_ff == '0) begin
          done = 1'b1;
          nxt_state = RX_IDLE;
        end
      end
    endcase
    if (!active) nxt_state = RX_IDLE;
  end

  // eight-bit characters sit in the top of the shifter
  assign rx_char = wide ? shreg_ff : {1'b0, shreg_ff[8:1]};
  assign accept = done && active &&
                  (!addr_det || (wide && rx_char[8]));
  assign pop = complete && pop_ok_ff && port_on;
  assign push = accept && ((count_ff != FULL_CNT) || pop);
  assign wr_en = push;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RX_IDLE;
      tmr_ff <= '0;
      bitn_ff <= 4'h0;
      shreg_ff <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      bitn_ff <= nxt_bitn;
      shreg_ff <= nxt_shreg;
    end
  end

  // queue pointers and overrun; disabling the port empties everything
  always_comb begin
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_ovr = ovr_ff;
    if (pop) nxt_rd_ptr = rd_ptr_ff + 1'b1;
    nxt_count = count_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    if (accept && !push) nxt_ovr = 1'b1; // third character
    if (!rx_on) nxt_ovr = 1'b0; // queue kept
    if (!port_on) begin
      nxt_rd_ptr = '0; // unit reset
      nxt_count = '0;
      nxt_ovr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ovr_ff <= 1'b0;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      ovr_ff <= nxt_ovr;
    end
  end

  // entry store: framing error and ninth bit kept per character
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      logic [9:0] nxt_entry;
      always_comb begin
        nxt_entry = mem_ff[gi];
        if (wr_en && (wr_ptr == PW'(gi)))
          nxt_entry = {!serial_rx, rx_char};
        if (!port_on) nxt_entry = 10'h000;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mem_ff[gi] <= 10'h000;
        else mem_ff[gi] <= nxt_entry;
      end
    end
  endgenerate

  // sticky events cleared by reading them; a new event beats the clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (complete) nxt_irq_stat = irq_stat_ff & ~irq_clr_ff;
    if (push) nxt_irq_stat[`IRQ_RXCHAR] = 1'b1; // framing adds none
    if (accept && !push) nxt_irq_stat[`IRQ_OVERRUN] = 1'b1;
    nxt_irq = |(nxt_irq_stat & irq_mask_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

  // checks next to the logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  frame_store_a: assert property (push |=> mem_ff[$past(wr_ptr)][9] ==
      $past(!serial_rx)) else $error("framing status not stored");
  frame_top_a: assert property (pop && !push && count_ff > 1 |=>
      status_word[`STAT_FRAME] == $past(mem_ff[PW'(rd_ptr_ff + 1'b1)][9]))
    else $error("framing flag not from next entry");
  pop_advance_a: assert property (pop && !push && port_on |=>
      count_ff == $past(count_ff) - 1'b1) else $error("read did not pop");
  frame_no_block_a: assert property (accept && !serial_rx &&
      count_ff == '0 |=> count_ff != '0) else $error("framing blocked rx");
  port_off_clear_a: assert property (!port_on |=> count_ff == '0 &&
      !ovr_ff && !status_word[`STAT_FRAME])
    else $error("port disable left state");
  rx_off_keep_a: assert property (!rx_on && port_on && !pop |=>
      $stable(status_word[`STAT_FRAME])) else $error("framing flag moved");
  no_frame_irq_a: assert property ($rose(irq_stat_ff[`IRQ_RXCHAR]) |->
      $past(push)) else $error("receive event without a queued char");
  overrun_set_a: assert property (accept && count_ff == FULL_CNT &&
      !pop && rx_on |=> ovr_ff) else $error("overrun not flagged");
  overrun_hold_a: assert property (ovr_ff |-> !push &&
      state_ff == RX_IDLE) else $error("receiving during overrun");
  overrun_clr_a: assert property (ovr_ff && !rx_on |=> !ovr_ff)
    else $error("overrun not cleared");
  nine_bits_a: assert property ($rose(state_ff == RX_STOP) |->
      $past(bitn_ff) == nbits - 4'h1) else $error("wrong bit count");
  addr_filter_a: assert property (push && addr_det |-> rx_char[8])
    else $error("non address character queued");
  apb_answer_a: assert property (setup |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle");

  cov_frame_c: cover property (push && !serial_rx);
  cov_overrun_c: cover property ($rose(ovr_ff));
  cov_nine_c: cover property (push && wide && rx_char[8]);
  cov_filter_c: cover property (done && addr_det && !accept);
endmodule // async_serial_receive_status

// >>> dv/serial_tx_model.sv
// behavioural remote transmitter driving the serial receive line
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic pclk,
  output logic serial_rx
);
  // line idles high between frames
  initial serial_rx = 1'b1;

  // one bit held for BIT_CYC cycles, changed just after an edge
  task automatic put(input logic b);
    serial_rx <= b;
    repeat (BIT_CYC) @(posedge pclk);
  endtask

  // start, data lsb first, stop (low when broken), then idle
  task automatic send(input logic [8:0] d, input int nb, input logic ok);
    @(posedge pclk);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    put(ok);
    put(1'b1);
    put(1'b1);
  endtask
endmodule // serial_tx_model

// >>> dv/test_async_serial_receive_status.sv
// self-checking bench for the serial receive status block
`timescale 1ns/1ps
`include "serial_rx_defines.svh"
module test_async_serial_receive_status;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_rx;
  logic irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] exp_q[$];
  logic [8:0] c[4];
  int n_errors, tests_run;

  async_serial_receive_status dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx(serial_rx), .irq(irq));
  serial_tx_model #(.BIT_CYC(4)) tx_u (.pclk(pclk), .serial_rx(serial_rx));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] e);
    tests_run++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // completed reads take the oldest note off the queue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  end

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(a, 1'b0, 32'h0, e);
  endtask

  task automatic dat(input int i);
    rd(`OFS_DATA, {25'h0, c[i][7:0]});
  endtask

  // next state of the bench lfsr
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // fresh random characters from the lfsr
  task automatic next_chars();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      c[i] = rnd[8:0];
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    tests_run = 0;
    rnd = 32'h21334519;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    rd(`OFS_CTRL, 33'h0);
    rd(`OFS_BAUD, 33'h10);
    rd(8'h18, 33'h100000000);
    $display("test reset done");
    // framing error per entry, read-only flag, no interrupt from it
    next_chars();
    wr(`OFS_BAUD, 32'h4);
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_CTRL, 32'h3);
    tx_u.send(c[0], 8, 1'b1);
    chk({32'h0, irq}, 33'h1);
    tx_u.send(c[1], 8, 1'b0);
    rd(`OFS_STATUS, 33'h8);
    dat(0);
    rd(`OFS_STATUS, 33'h9);
    wr(`OFS_STATUS, 32'h0);
    rd(`OFS_STATUS, 33'h9);
    tx_u.send(c[2], 8, 1'b1);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_STATUS, 33'h9);
    rd(`OFS_IRQ_STAT, 33'h1);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    dat(1);
    rd(`OFS_STATUS, 33'h8);
    dat(2);
    rd(`OFS_STATUS, 33'h0);
    $display("test framing done");
    // overrun with interrupt masked, cleared by dropping receive enable
    next_chars();
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_CTRL, 32'h3);
    for (int i = 0; i < 3; i++) tx_u.send(c[i], 8, 1'b1);
    rd(`OFS_STATUS, 33'hA);
    chk({32'h0, irq}, 33'h0);
    tx_u.send(c[3], 8, 1'b1);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_STATUS, 33'h8);
    rd(`OFS_IRQ_STAT, 33'h3);
    dat(0);
    dat(1);
    rd(`OFS_STATUS, 33'h0);
    // overrun and framing error cleared by port disable
    wr(`OFS_CTRL, 32'h3);
    tx_u.send(c[0], 8, 1'b0);
    tx_u.send(c[1], 8, 1'b1);
    tx_u.send(c[2], 8, 1'b1);
    rd(`OFS_STATUS, 33'hB);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_STATUS, 33'h0);
    $display("test overrun done");
    // nine-bit characters and address filtering
    next_chars();
    c[0][8] = 1'b1;
    c[1][8] = 1'b0;
    wr(`OFS_CTRL, 32'h7);
    tx_u.send(c[0], 9, 1'b1);
    rd(`OFS_STATUS, 33'hC);
    dat(0);
    wr(`OFS_CTRL, 32'hF);
    tx_u.send(c[1], 9, 1'b1);
    rd(`OFS_STATUS, 33'h0);
    tx_u.send(c[0], 9, 1'b1);
    wr(`OFS_CTRL, 32'h7);
    tx_u.send(c[1], 9, 1'b1);
    rd(`OFS_STATUS, 33'hC);
    dat(0);
    rd(`OFS_STATUS, 33'h8);
    dat(1);
    // address detect without nine-bit mode drops every character
    wr(`OFS_CTRL, 32'hB);
    tx_u.send(c[0], 8, 1'b1);
    rd(`OFS_STATUS, 33'h0);
    $display("test nine bit done");
    end_sim();
  end
endmodule // test_async_serial_receive_status
